//--- logic/apdr_ctrl.v
// Phase delay, filter and reset control for a two-channel converter.
// Assumes modulator bitstreams arrive synchronous to REF_CLK_I and
// that software reaches the registers over APB.
`timescale 1ns/1ps
`include "apdr_map.vh"

module apdr_ctrl #(
    parameter MODCLK_DIV = `APDR_MODCLK_CYC
) (
    // Clock and power-on reset
    input wire REF_CLK_I,
    input wire RESET_N_I,
    // Hard reset pin
    input wire HARD_RESET_N_I,
    // APB slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output wire PREADY_O,
    output wire PSLVERR_O,
    output wire [31:0] PRDATA_O,
    // Modulator side
    input wire [1:0] MOD_BIT_I,
    output wire MOD_CLEAR_O,
    output wire [7:0] COMP_O,
    // Reference control
    output wire REF_EXT_SEL_O,
    output wire [7:0] REF_TRIM_O,
    // Channel results
    output wire [23:0] CH0_CODE_O,
    output wire [23:0] CH1_CODE_O,
    output wire [1:0] CH_READY_O,
    // Sample ready pin and serial driver enable
    output wire SAMPLE_READY_N_O,
    output wire SAMPLE_READY_OE_O,
    output wire SER_OE_O
);

    // ----------------------------------------
    // Reset combination
    // ----------------------------------------

    // Pin acts on the very next edge, without a sampling delay
    wire rst_all = ~RESET_N_I | ~HARD_RESET_N_I;

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    reg [7:0] trim_q;
    reg ext_q;
    reg [2:0] ratio_q;
    reg [1:0] pre_q;
    reg [11:0] skew_q;

    // ----------------------------------------
    // APB handshake
    // ----------------------------------------
    reg pready_q;
    reg pslverr_q;
    reg [31:0] prdata_q;
    reg [31:0] rd_d;
    reg map_d;

    // Write lands in the access cycle only
    wire wr_go = PSEL_I & PENABLE_I & pready_q & PWRITE_I;

    // Pin low blocks writes, so nothing changes
    wire wr_ok = wr_go & HARD_RESET_N_I;

    // ----------------------------------------
    // Modulator clock
    // ----------------------------------------
    reg [13:0] div_q;
    reg tick_q;
    reg run_q;

    // Prescale doubles the period per step
    wire [13:0] div_lim = ({2'h0, MODCLK_DIV[11:0]} << pre_q) - 14'h0001;

    // ----------------------------------------
    // Ratio and skew decode
    // ----------------------------------------
    wire [12:0] decimation_ratio = 13'h0020 << ratio_q;
    wire [12:0] half = 13'h0010 << ratio_q;
    wire [2:0] sh = 3'h7 - ratio_q;

    // Move the sign bit to the top, then back down
    wire [11:0] skew_up = skew_q << sh;
    wire signed [11:0] skew_eff = $signed(skew_up) >>> sh;

    // Narrowed code can only span minus half to half minus one
    wire [12:0] start0 = half + {skew_eff[11], skew_eff};

    // Both channels start on one modulator edge
    wire load = tick_q & ~run_q;

    // ----------------------------------------
    // Register write and control state
    // ----------------------------------------

    // Defaults come back on either reset
    always @(posedge REF_CLK_I) begin
        if (rst_all) begin
            trim_q <= `APDR_TRIM_RST;
            ext_q <= `APDR_EXTREF_RST;
            ratio_q <= `APDR_RATIO_RST;
            pre_q <= `APDR_PRE_RST;
            skew_q <= `APDR_SKEW_RST;
        end else if (wr_ok) begin
            case (PADDR_I)
                `APDR_OFS_CFG0: begin
                    trim_q <= PWDATA_I[`APDR_TRIM_LSB +: 8];
                end
                `APDR_OFS_CFG1: begin
                    ext_q <= PWDATA_I[`APDR_EXTREF_BIT];
                    ratio_q <= PWDATA_I[`APDR_RATIO_LSB +: 3];
                    pre_q <= PWDATA_I[`APDR_PRE_LSB +: 2];
                end
                `APDR_OFS_SKEW: begin
                    skew_q <= PWDATA_I[11:0];
                end
                default: begin
                    skew_q <= skew_q;
                end
            endcase
        end
    end

    // Run flag drops on reset or skew write, rises on a tick
    always @(posedge REF_CLK_I) begin
        if (rst_all) begin
            run_q <= 1'b0;
        end else if (wr_ok && PADDR_I == `APDR_OFS_SKEW) begin
            run_q <= 1'b0;
        end else if (tick_q) begin
            run_q <= 1'b1;
        end
    end

    // Divider restarts with reset so the first tick is deterministic
    always @(posedge REF_CLK_I) begin
        if (rst_all) begin
            div_q <= 14'h0000;
            tick_q <= 1'b0;
        end else if (div_q >= div_lim) begin
            div_q <= 14'h0000;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 14'h0001;
            tick_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    wire [1:0] rdy;
    wire [27:0] code_w;
    wire [7:0] comp_w;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            reg [12:0] cnt_q;
            reg [12:0] acc_q;
            reg [13:0] code_q;
            reg rdy_q;
            reg [3:0] cmp_q;
            wire m = MOD_BIT_I[g];

            // Channel one waits half a ratio, channel zero adds skew
            wire [12:0] start = (g == 0) ? start0 : half;

            // Filter, counter and buffer share one reset path
            always @(posedge REF_CLK_I) begin
                if (rst_all) begin
                    cnt_q <= 13'h0000;
                    acc_q <= 13'h0000;
                    code_q <= 14'h0000;
                    rdy_q <= 1'b0;
                    cmp_q <= `APDR_COMP_RST;
                end else begin
                    rdy_q <= 1'b0;
                    cmp_q <= {m, m, ~m, ~m};
                    if (load) begin
                        cnt_q <= start;
                        acc_q <= 13'h0000;
                    end else if (tick_q) begin
                        if (cnt_q == 13'h0000) begin
                            // Frame end: latch code, fire ready
                            rdy_q <= 1'b1;
                            code_q <= {acc_q, 1'b0} - {1'b0, decimation_ratio};
                            acc_q <= {12'h000, m};
                            cnt_q <= decimation_ratio - 13'h0001;
                        end else begin
                            cnt_q <= cnt_q - 13'h0001;
                            acc_q <= acc_q + {12'h000, m};
                        end
                    end
                end
            end

            assign rdy[g] = rdy_q;
            assign code_w[g*14 +: 14] = code_q;
            assign comp_w[g*4 +: 4] = cmp_q;
        end
    endgenerate

    // ----------------------------------------
    // Pin outputs
    // ----------------------------------------
    reg ready_n_q;
    reg pin_oe_q;
    reg mod_clr_q;
    reg [1:0] ch_rdy_q;

    // Pulses from both channels share the pin, one cycle low each; coinciding pulses give a single low cycle
    always @(posedge REF_CLK_I) begin
        if (rst_all) begin
            ready_n_q <= 1'b1;
            pin_oe_q <= 1'b0;
            mod_clr_q <= 1'b1;
            ch_rdy_q <= 2'h0;
        end else begin
            ready_n_q <= ~(rdy[0] | rdy[1]);
            pin_oe_q <= 1'b1;
            mod_clr_q <= 1'b0;
            ch_rdy_q <= rdy;
        end
    end

    // ----------------------------------------
    // APB read path
    // ----------------------------------------

    // Read mux; unmapped offsets answer with an error
    always @* begin
        rd_d = 32'h0000_0000;
        map_d = 1'b1;
        case (PADDR_I)
            `APDR_OFS_CFG0: begin
                rd_d[7:0] = trim_q;
            end
            `APDR_OFS_CFG1: begin
                rd_d[`APDR_EXTREF_BIT] = ext_q;
                rd_d[`APDR_RATIO_LSB +: 3] = ratio_q;
                rd_d[`APDR_PRE_LSB +: 2] = pre_q;
            end
            `APDR_OFS_SKEW: begin
                rd_d[11:0] = skew_q;
            end
            `APDR_OFS_STAT: begin
                rd_d[0] = run_q;
                rd_d[1] = ~HARD_RESET_N_I;
            end
            `APDR_OFS_CODE0: begin
                rd_d = {{18{code_w[13]}}, code_w[13:0]};
            end
            `APDR_OFS_CODE1: begin
                rd_d = {{18{code_w[27]}}, code_w[27:14]};
            end
            default: begin
                map_d = 1'b0;
            end
        endcase
    end

    // Answer one cycle after setup: ready is high in the access cycle
    always @(posedge REF_CLK_I) begin
        if (~RESET_N_I) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= PSEL_I & ~PENABLE_I;
            if (PSEL_I & ~PENABLE_I) begin
                pslverr_q <= ~map_d;
                prdata_q <= PWRITE_I ? 32'h0000_0000 : rd_d;
            end else begin
                pslverr_q <= 1'b0;
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // Output wiring, all from flops
    // ----------------------------------------
    assign PREADY_O = pready_q;
    assign PSLVERR_O = pslverr_q;
    assign PRDATA_O = prdata_q;
    assign MOD_CLEAR_O = mod_clr_q;
    assign COMP_O = comp_w;

    // Analog side picks the reference from this bit
    assign REF_EXT_SEL_O = ext_q;
    assign REF_TRIM_O = trim_q;
    assign CH0_CODE_O = {{10{code_w[13]}}, code_w[13:0]};
    assign CH1_CODE_O = {{10{code_w[27]}}, code_w[27:14]};
    assign CH_READY_O = ch_rdy_q;
    assign SAMPLE_READY_N_O = ready_n_q;
    assign SAMPLE_READY_OE_O = pin_oe_q;
    assign SER_OE_O = pin_oe_q;

endmodule // apdr_ctrl

//--- logic/apdr_map.vh
// Constants for the converter phase delay and reset controller.
// Assumes a 250 MHz REF_CLK_I and an APB slave with 32-bit data.
`ifndef APDR_MAP_VH
`define APDR_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define APDR_OFS_CFG0 8'h00
`define APDR_OFS_CFG1 8'h04
`define APDR_OFS_SKEW 8'h08
`define APDR_OFS_STAT 8'h0c
`define APDR_OFS_CODE0 8'h10
`define APDR_OFS_CODE1 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define APDR_TRIM_LSB 0
`define APDR_EXTREF_BIT 0
`define APDR_RATIO_LSB 1
`define APDR_PRE_LSB 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define APDR_TRIM_RST 8'h50
`define APDR_EXTREF_RST 1'h0
`define APDR_RATIO_RST 3'h3
`define APDR_PRE_RST 2'h0
`define APDR_SKEW_RST 12'h000
`define APDR_COMP_RST 4'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define APDR_CLK_MHZ 250
`define APDR_MODCLK_NS 1000
`define APDR_MODCLK_CYC (`APDR_MODCLK_NS * `APDR_CLK_MHZ / 1000)

`endif

//--- tb/apdr_mod_src.sv
// Modulator bitstream source for both channels.
// Assumes bits are sampled by the controller on its own ticks.
`timescale 1ns/1ps
module apdr_mod_src #(parameter [1:0] PATTERN = 2'h1) (
    // Clock
    input wire clk_i,
    // Bitstreams, bit0 is channel zero
    output reg [1:0] bits_o
);
    // Held steady so each full frame yields a known code
    initial bits_o = PATTERN;
    always @(posedge clk_i) begin
        bits_o <= PATTERN;
    end
endmodule // apdr_mod_src

//--- tb/apdr_props.sv
// Checker for the converter phase delay and reset controller.
// Assumes it watches apdr_ctrl ports only, bound below.
`timescale 1ns/1ps
module apdr_props #(parameter MODCLK_DIV = 250) (
    // Clock and resets
    input wire REF_CLK_I,
    input wire RESET_N_I,
    input wire HARD_RESET_N_I,
    // APB
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire PREADY_O,
    input wire PSLVERR_O,
    input wire [31:0] PRDATA_O,
    // Outputs watched
    input wire MOD_CLEAR_O,
    input wire [7:0] COMP_O,
    input wire REF_EXT_SEL_O,
    input wire [7:0] REF_TRIM_O,
    input wire [23:0] CH0_CODE_O,
    input wire [23:0] CH1_CODE_O,
    input wire [1:0] CH_READY_O,
    input wire SAMPLE_READY_N_O,
    input wire SAMPLE_READY_OE_O,
    input wire SER_OE_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // ----------------------------------------
    // Hard reset steps
    // ----------------------------------------
    sequence pin_low_s;
        !HARD_RESET_N_I;
    endsequence
    sequence pin_held_s;
        !HARD_RESET_N_I [*2];
    endsequence
    pins_released_a: assert property (pin_low_s |=> !SAMPLE_READY_OE_O && !SER_OE_O)
        else $error("pins driven in reset");
    codes_zero_a: assert property (pin_low_s |=> CH0_CODE_O == 24'h0 && CH1_CODE_O == 24'h0)
        else $error("code not zero in reset");
    comp_pattern_a: assert property (pin_low_s |=> COMP_O == 8'h33 && MOD_CLEAR_O)
        else $error("modulator not cleared");
    ready_quiet_a: assert property (pin_low_s |=> SAMPLE_READY_N_O && CH_READY_O == 2'h0)
        else $error("ready pulse in reset");
    trim_held_a: assert property (pin_held_s |=> REF_TRIM_O == 8'h50)
        else $error("trim changed in reset");
    // ----------------------------------------
    // Run time relations
    // ----------------------------------------
    ready_pin_a: assert property (CH_READY_O != 2'h0 |-> !SAMPLE_READY_N_O)
        else $error("pin missed a ready pulse");
    ext_sel_a: assert property (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == 8'h04 &&
        HARD_RESET_N_I |=> REF_EXT_SEL_O == $past(PWDATA_I[0]))
        else $error("ext select not taken");
    apb_answer_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
        else $error("apb answer not one cycle");
    apb_error_a: assert property (PSEL_I && !PENABLE_I && PADDR_I > 8'h14 |=> PSLVERR_O && PRDATA_O == 32'h0)
        else $error("unmapped access not refused");
endmodule // apdr_props

bind apdr_ctrl apdr_props #(.MODCLK_DIV(MODCLK_DIV)) apdr_props_inst (.*);

//--- tb/tb_apdr_ctrl.sv
// Testbench for the converter phase delay and reset controller.
// Assumes a 4-cycle modulator tick and ratio 32 in the skew runs.
`timescale 1ns/1ps
module tb_apdr_ctrl;
    logic clk = 0, rst_n = 0, hrst_n = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, r;
    logic e;
    wire [1:0] mod_bits, rdy;
    wire [31:0] prdata;
    wire [23:0] code0, code1;
    wire [7:0] comp, trim;
    wire pready, perr, clr, ext, rdy_n, rdy_oe, ser_oe;
    int n_fail = 0, n_checks = 0, cyc = 0, last0 = 0, last1 = 0, prev1 = 0;
    always #2 clk = ~clk;
    apdr_mod_src apdr_mod_src_inst (.clk_i(clk), .bits_o(mod_bits));
    apdr_ctrl #(.MODCLK_DIV(4)) apdr_ctrl_inst (.REF_CLK_I(clk), .RESET_N_I(rst_n), .HARD_RESET_N_I(hrst_n),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PREADY_O(pready), .PSLVERR_O(perr), .PRDATA_O(prdata), .MOD_BIT_I(mod_bits), .MOD_CLEAR_O(clr),
        .COMP_O(comp), .REF_EXT_SEL_O(ext), .REF_TRIM_O(trim), .CH0_CODE_O(code0), .CH1_CODE_O(code1),
        .CH_READY_O(rdy), .SAMPLE_READY_N_O(rdy_n), .SAMPLE_READY_OE_O(rdy_oe), .SER_OE_O(ser_oe));
    // Pulse times; a hang past the ceiling ends the run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rdy[0] === 1'b1) last0 <= cyc;
        if (rdy[1] === 1'b1) begin
            last1 <= cyc;
            prev1 <= last1;
        end
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer, held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // Answer and read data are taken at the same edge
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) n_fail++;
        r = prdata;
        e = perr;
        psel <= 0; penable <= 0;
    endtask
    task wait_ch1;
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rdy[1] !== 1'b1 && n < 600);
        if (rdy[1] !== 1'b1) n_fail++;
    endtask
    task t_defaults;
        apb(0, 8'h00, 0); check("trim_rd", r, 32'h50);
        apb(0, 8'h04, 0); check("cfg1_rd", r, 32'h6);
        apb(0, 8'h08, 0); check("skew_rd", r, 32'h0);
        check("trim_pin", trim, 8'h50);
        // Defaults alone must bring the ready pin to life
        wait_ch1();
        check("por_ready", {rdy[1], rdy_n}, 2'h2);
        check("pins_run", {rdy_oe, ser_oe, clr, comp}, 11'h63c);
    endtask
    task t_regs;
        apb(1, 8'h00, 32'h42); apb(0, 8'h00, 0); check("trim_wr", r, 32'h42);
        apb(1, 8'h04, 32'h7);
        @(posedge clk);
        check("ext_sel", ext, 1'b1);
        apb(0, 8'h20, 0); check("bad_err", e, 1'b1);
        check("bad_data", r, 32'h0);
    endtask
    task t_hard;
        @(posedge clk) hrst_n <= 0;
        repeat (3) @(posedge clk);
        check("oe", {rdy_oe, ser_oe, rdy_n}, 3'h1);
        check("code0_rst", code0, 24'h0);
        check("code1_rst", code1, 24'h0);
        check("comp", {clr, comp}, 9'h133);
        apb(1, 8'h00, 32'h11);
        @(posedge clk) hrst_n <= 1;
        apb(0, 8'h00, 0); check("trim_rst", r, 32'h50);
        apb(0, 8'h04, 0); check("cfg1_rst", r, 32'h6);
    endtask
    // Gap of channel zero after channel one, in clock cycles
    task t_skew(input logic [11:0] code, input int gap);
        int t0;
        apb(1, 8'h08, {20'h0, code});
        t0 = cyc;
        // First frame after a restart is partial, so it is skipped
        wait_ch1();
        wait_ch1();
        repeat (70) @(posedge clk);
        // Restart: load on the next tick, then half a ratio plus one tick
        check("restart", 32'(prev1 - t0 >= 71 && prev1 - t0 <= 74), 32'd1);
        check("skew_gap", 32'(last0 - last1), 32'(gap));
        check("frame", 32'(last1 - prev1), 32'd128);
        check("code0", code0, 24'h20);
        check("code1", code1, 24'hffffe0);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        t_defaults();
        t_regs();
        t_hard();
        apb(1, 8'h04, 32'h0);
        t_skew(12'h005, 20);
        t_skew(12'h005, 20);
        t_skew(12'hffd, -12);
        t_skew(12'h01d, -12);
        t_skew(12'h00f, 60);
        finish_test();
    end
endmodule // tb_apdr_ctrl
